// file: common/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
// register indices and byte addresses (four times index)
`define INT_EN_1_INDEX    8'h00
`define INT_EN_2_INDEX    8'h01
`define INT_FLAG_1_INDEX  8'h02
`define INT_FLAG_2_INDEX  8'h03
`define MODE_INDEX        8'h04
`define STAT_INDEX        8'h05
`define ADDR_INT_EN_1     8'h00
`define ADDR_INT_EN_2     8'h04
`define ADDR_INT_FLAG_1   8'h08
`define ADDR_INT_FLAG_2   8'h0C
`define ADDR_MODE         8'h10
`define ADDR_STAT         8'h14
// enable and flag bit positions
`define BIT_WDOG        0
`define BIT_OSC         1
`define BIT_NMI         4
`define BIT_FLASH       5
// implemented bit mask of both enable and flag registers
`define SPECIAL_MASK    8'h33
// mode register fields
`define MODE_OSC_BIT    3
`define MODE_WDOG_BIT   4
// vector table
`define VEC_BASE        16'hFFE0
`define PRIO_RESET      4'hF
`define PRIO_NMI        4'hE
`define PRIO_WDOG       4'hA
`define PRIO_TMR0       4'h9
`define PRIO_TMR12      4'h8
`define PRIO_PORT2      4'h3
`define PRIO_PORT1      4'h2
// bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// file: common/irq_pkg.sv
package irq_pkg;
  // operating modes
  typedef enum logic [2:0] {
    active_run_mode, low_power_mode_0, low_power_mode_1,
    low_power_mode_2, low_power_mode_3, low_power_mode_4
  } power_mode_t;
  // clock and oscillator controls
  typedef struct packed {
    logic cpu_run;
    logic mclk_en;
    logic sub_main_clock_en;
    logic aclk_en;
    logic dco_gen_en;
    logic xtal_en;
  } clk_ctrl_t;
  // bus master to slave
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } axi_req_t;
  // bus slave to master
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;
endpackage : irq_pkg

// file: core/irq_vector_lowpower_ctrl.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module irq_vector_lowpower_ctrl
  import irq_pkg::*;
(
  // clock and power-on reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // power-up clear pulse from reset logic
  input  wire logic        power_up_clear,
  // register bus
  input  wire axi_req_t    axi_req,
  output axi_rsp_t         axi_rsp,
  // reset and non-maskable sources
  input  wire logic        pin_reset_mode,
  input  wire logic        pin_reset,
  input  wire logic        pin_nmi_req,
  input  wire logic        wdog_overflow,
  input  wire logic        flash_key_violation,
  input  wire logic        osc_fault_det,
  input  wire logic        flash_access_viol,
  input  wire logic        true_nmi_req,
  // maskable sources, flags held in their modules
  input  wire logic        timer_channel0,
  input  wire logic        timer_channel1,
  input  wire logic        timer_channel2,
  input  wire logic        timer_overflow_flag,
  input  wire logic [7:0]  port1_edge_flags,
  input  wire logic [7:0]  port2_edge_flags,
  // processor core
  input  wire logic        gie,
  input  wire logic        irq_ack,
  input  wire logic        irq_return,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic             sys_reset_req,
  // clock system
  output clk_ctrl_t        clk_ctrl
);

  // whole state of the block
  typedef struct packed {
    axi_rsp_t    rsp;          // bus answer flops
    logic        aw_got;       // write address held
    logic        w_got;        // write data held
    logic [7:0]  aw_addr;      // held write address
    logic [7:0]  w_data;       // held low write byte
    logic        w_lane0;      // low byte lane enabled
    logic [7:0]  ie1;          // enable register
    logic [7:0]  interrupt_flag_1;         // flag register
    logic        dco_in_active; // oscillator feeds active mode
    logic        wdog_interval; // watchdog in interval mode
    power_mode_t mode;         // current operating mode
    power_mode_t saved_mode;   // mode to restore on return
    logic        woken;        // woken from low-power mode
    logic        irq_req;
    logic [15:0] irq_vector;
    logic        sys_reset_req;
    clk_ctrl_t   clk_ctrl;
  } state_t;

  state_t st;        // registered state
  state_t next_st;   // next state

  // word address of a vector slot
  function automatic logic [15:0] vec_addr(input logic [3:0] prio);
    vec_addr = `VEC_BASE + {11'h000, prio, 1'b0};
  endfunction : vec_addr

  // clock set for each mode
  function automatic clk_ctrl_t mode_clocks(input power_mode_t m, input logic dco_act);
    clk_ctrl_t c;
    // start from the common low-power set: processor halted, main clock off
    // every low-power mode below only turns off what it must; anything not named keeps the set above
    c = '{cpu_run: 1'b0, mclk_en: 1'b0, sub_main_clock_en: 1'b1, aclk_en: 1'b1,
          dco_gen_en: 1'b1, xtal_en: 1'b1};
    unique case (m)
      active_run_mode: begin
        // processor executes, main clock restored
        c.cpu_run = 1'b1;
        c.mclk_en = 1'b1;
      end
      low_power_mode_0: begin
        // auxiliary and sub-main keep peripherals alive
        c.mclk_en = 1'b0;
      end
      low_power_mode_1: begin
        // keeping the generator on when active mode needs it saves the
        // restart time of the oscillator on wake-up
        c.dco_gen_en = dco_act;
      end
      low_power_mode_2: begin
        // peripherals on sub-main clock freeze here
        c.sub_main_clock_en = 1'b0;
      end
      low_power_mode_3: begin
        // generator off too, so wake-up is slower than mode 2
        c.sub_main_clock_en = 1'b0;
        c.dco_gen_en        = 1'b0;
      end
      low_power_mode_4: begin
        // only an event that needs no clock can wake the part from here
        c.sub_main_clock_en = 1'b0;
        c.aclk_en    = 1'b0;
        c.dco_gen_en = 1'b0;
        c.xtal_en    = 1'b0;
      end
    endcase
    mode_clocks = c;
  endfunction : mode_clocks

  // read value at a register byte address, valid flag beside it
  function automatic logic [32:0] reg_read(input state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    unique case (a)
      // only assigned bits exist
      // enable register, unassigned bits read as zero
      `ADDR_INT_EN_1:   r[7:0] = s.ie1 & `SPECIAL_MASK;
      // second enable register has no bits at all
      `ADDR_INT_EN_2:   r[7:0] = 8'h00;
      // flag register, unassigned bits read as zero
      `ADDR_INT_FLAG_1: r[7:0] = s.interrupt_flag_1 & `SPECIAL_MASK;
      // second flag register has no bits at all
      `ADDR_INT_FLAG_2: r[7:0] = 8'h00;
      // mode and status are plain read-back
      `ADDR_MODE: r[7:0] = {3'h0, s.wdog_interval, s.dco_in_active, s.mode};
      `ADDR_STAT: r[23:0] = {s.irq_vector, 6'h00, s.woken, s.irq_req};
      default:    r[32] = 1'b0;
    endcase
    reg_read = r;
  endfunction : reg_read

  // request lines by slot
  logic        req_reset;  // slot 15
  logic        req_nmi;    // slot 14
  logic        req_wdog;   // slot 10
  logic        req_tmr0;   // slot 9
  logic        req_tmr12;  // slot 8
  logic        req_port2;  // slot 3
  logic        req_port1;  // slot 2
  logic        any_req;    // something to serve
  logic [3:0]  win_prio;   // winning slot

  // request gating and priority pick
  always_comb begin
    req_reset = pin_reset & pin_reset_mode | flash_key_violation
                | wdog_overflow & ~st.wdog_interval;
    // own enables only, no general enable
    req_nmi = st.interrupt_flag_1[`BIT_NMI] & st.ie1[`BIT_NMI]
              | st.interrupt_flag_1[`BIT_OSC] & st.ie1[`BIT_OSC]
              | st.interrupt_flag_1[`BIT_FLASH] & st.ie1[`BIT_FLASH];
    req_nmi = req_nmi | true_nmi_req;
    // enable counts only in interval mode
    req_wdog = gie & st.wdog_interval & st.ie1[`BIT_WDOG] & st.interrupt_flag_1[`BIT_WDOG];
    req_tmr0  = gie & timer_channel0;
    req_tmr12 = gie & (timer_channel1 | timer_channel2 | timer_overflow_flag);
    req_port2 = gie & (|port2_edge_flags);
    // port 1 flags from port module
    req_port1 = gie & (|port1_edge_flags);
    any_req = req_reset | req_nmi | req_wdog | req_tmr0 | req_tmr12
              | req_port2 | req_port1;
    // highest number wins, empty slots unused
    if (req_reset) begin
      win_prio = `PRIO_RESET;
    end else if (req_nmi) begin
      win_prio = `PRIO_NMI;
    end else if (req_wdog) begin
      win_prio = `PRIO_WDOG;
    end else if (req_tmr0) begin
      win_prio = `PRIO_TMR0;
    end else if (req_tmr12) begin
      win_prio = `PRIO_TMR12;
    end else if (req_port2) begin
      win_prio = `PRIO_PORT2;
    end else begin
      win_prio = `PRIO_PORT1;
    end
  end

  logic        do_write;  // both write halves present
  logic [32:0] rd_val;    // read lookup

  // next state
  always_comb begin
    next_st = st;
    do_write = st.aw_got & st.w_got & ~st.rsp.bvalid;
    rd_val = reg_read(st, axi_req.araddr);

    // write address and data, either order
    if (st.rsp.awready & axi_req.awvalid) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = axi_req.awaddr;
    end
    if (st.rsp.wready & axi_req.wvalid) begin
      next_st.w_got   = 1'b1;
      next_st.w_data  = axi_req.wdata[7:0];
      next_st.w_lane0 = axi_req.wstrb[0];
    end

    // software writes come first; the hardware flag sets further down
    // overwrite them, so a set in the same cycle as a clearing write wins
    if (do_write) begin
      // both halves consumed, response raised for the next cycle
      next_st.aw_got     = 1'b0;
      next_st.w_got      = 1'b0;
      next_st.rsp.bvalid = 1'b1;
      next_st.rsp.bresp  = `RESP_OKAY;
      // only the low byte lane carries register data
      unique case (st.aw_addr)
        `ADDR_INT_EN_1: begin
          if (st.w_lane0) begin
            // unassigned positions never hold a one
            next_st.ie1 = st.w_data & `SPECIAL_MASK;
          end
        end
        `ADDR_INT_FLAG_1: begin
          // software may set or clear flags
          if (st.w_lane0) begin
            // setting a flag by software raises its request like hardware
            next_st.interrupt_flag_1 = st.w_data & `SPECIAL_MASK;
          end
        end
        `ADDR_MODE: begin
          if (st.w_lane0) begin
            // codes 6 and 7 leave the mode as it is
            next_st.dco_in_active = st.w_data[`MODE_OSC_BIT];
            next_st.wdog_interval = st.w_data[`MODE_WDOG_BIT];
            if (st.w_data[2:0] <= 3'h5) begin
              next_st.mode = power_mode_t'(st.w_data[2:0]);
            end
          end
        end
        `ADDR_INT_EN_2, `ADDR_INT_FLAG_2, `ADDR_STAT: begin
          // no writable bits
        end
        default: next_st.rsp.bresp = `RESP_SLVERR;
      endcase
    end
    if (st.rsp.bvalid & axi_req.bready) begin
      next_st.rsp.bvalid = 1'b0;
    end
    // one of each half outstanding until answered
    next_st.rsp.awready = ~next_st.aw_got & ~next_st.rsp.bvalid;
    next_st.rsp.wready  = ~next_st.w_got & ~next_st.rsp.bvalid;

    // read channel, answer one cycle after address
    if (st.rsp.arready & axi_req.arvalid) begin
      next_st.rsp.arready = 1'b0;
      next_st.rsp.rvalid  = 1'b1;
      next_st.rsp.rdata   = rd_val[31:0];
      next_st.rsp.rresp   = rd_val[32] ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (st.rsp.rvalid & axi_req.rready) begin
      next_st.rsp.rvalid  = 1'b0;
      next_st.rsp.arready = 1'b1;
    end

    // watchdog flag sets on overflow or key violation
    if (wdog_overflow | flash_key_violation) begin
      next_st.interrupt_flag_1[`BIT_WDOG] = 1'b1;
    end else if (pin_reset & pin_reset_mode) begin
      next_st.interrupt_flag_1[`BIT_WDOG] = 1'b0;
    end else if (irq_ack & st.irq_req & (st.irq_vector == vec_addr(`PRIO_WDOG))) begin
      // interval flag is single source, cleared on service
      next_st.interrupt_flag_1[`BIT_WDOG] = 1'b0;
    end
    if (osc_fault_det) begin
      next_st.interrupt_flag_1[`BIT_OSC] = 1'b1;
    end
    if (pin_nmi_req & ~pin_reset_mode) begin
      next_st.interrupt_flag_1[`BIT_NMI] = 1'b1;
    end
    if (flash_access_viol) begin
      next_st.interrupt_flag_1[`BIT_FLASH] = 1'b1;
    end

    // any request wakes a low-power mode
    if (st.mode != active_run_mode && any_req && !st.woken) begin
      next_st.saved_mode = st.mode;
      next_st.mode       = active_run_mode;
      next_st.woken      = 1'b1;
    end
    // return goes back to saved mode
    if (irq_return & st.woken) begin
      next_st.mode  = st.saved_mode;
      next_st.woken = 1'b0;
    end

    // vector word for the winning slot
    next_st.irq_req       = any_req & ~req_reset;
    next_st.irq_vector    = vec_addr(win_prio);
    next_st.sys_reset_req = req_reset;
    next_st.clk_ctrl      = mode_clocks(next_st.mode, next_st.dco_in_active);

    if (power_up_clear) begin
      next_st.ie1        = 8'h00;
      next_st.interrupt_flag_1[`BIT_OSC]   = osc_fault_det;
      next_st.interrupt_flag_1[`BIT_NMI]   = 1'b0;
      next_st.interrupt_flag_1[`BIT_FLASH] = flash_access_viol;
      next_st.mode       = active_run_mode;
      next_st.saved_mode = active_run_mode;
      next_st.woken      = 1'b0;
      next_st.clk_ctrl   = mode_clocks(active_run_mode, next_st.dco_in_active);
    end
  end

  // state register; power-on reset clears all but the ready flags, the vector and the clocks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.rsp.awready <= 1'b1;
      st.rsp.wready  <= 1'b1;
      st.rsp.arready <= 1'b1;
      st.irq_vector  <= 16'hFFFE;
      // power-on leaves the part in active mode with every clock running
      st.clk_ctrl    <= '{cpu_run: 1'b1, mclk_en: 1'b1, sub_main_clock_en: 1'b1,
                          aclk_en: 1'b1, dco_gen_en: 1'b1, xtal_en: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign axi_rsp       = st.rsp;
  assign irq_req       = st.irq_req;
  assign irq_vector    = st.irq_vector;
  assign sys_reset_req = st.sys_reset_req;
  assign clk_ctrl      = st.clk_ctrl;

endmodule : irq_vector_lowpower_ctrl

// file: verif/irq_ctrl_monitor.sv
`timescale 1ns/1ps
module irq_ctrl_monitor
  import irq_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // register bus
  input wire axi_req_t    axi_req,
  input wire axi_rsp_t    axi_rsp,
  // sources and core
  input wire logic        flash_key_violation,
  input wire logic        true_nmi_req,
  input wire logic [7:0]  port1_edge_flags,
  input wire logic        gie,
  // outputs watched
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic        sys_reset_req,
  input wire clk_ctrl_t   clk_ctrl
);
  // one clock domain, power-on reset disables all
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_vector_in_table: assert property (
    irq_req |-> irq_vector[15:5] == 11'h7FF && !irq_vector[0]) else $error("vector off table");
  a_key_resets: assert property (
    flash_key_violation |=> sys_reset_req) else $error("key violation no reset");
  a_true_nmi_slot: assert property (
    true_nmi_req |=> irq_req && irq_vector == 16'hFFFC) else $error("true nmi not served");
  a_port1_request: assert property (
    gie && |port1_edge_flags |=> irq_req) else $error("port 1 request lost");
  a_active_clocks: assert property (
    clk_ctrl.cpu_run |-> &clk_ctrl) else $error("active mode clock off");
  a_halt_mclk: assert property (
    !clk_ctrl.cpu_run |-> !clk_ctrl.mclk_en) else $error("main clock runs while halted");
  a_sub_main_stop: assert property (
    !clk_ctrl.sub_main_clock_en |-> !clk_ctrl.cpu_run && clk_ctrl.aclk_en == clk_ctrl.xtal_en)
    else $error("sub-main stop inconsistent");
  a_all_stopped: assert property (
    !clk_ctrl.aclk_en |-> clk_ctrl == '0) else $error("clock runs with aux stopped");
  a_read_answer: assert property (
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid) else $error("read answer late");
  a_read_hold: assert property (
    axi_rsp.rvalid && !axi_req.rready |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  a_write_hold: assert property (
    axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped");
endmodule : irq_ctrl_monitor

// file: verif/core_model.sv
`timescale 1ns/1ps
module core_model
  import irq_pkg::*;
#(
  parameter int ACK_DELAY = 2 // cycles before the core takes a request
)(
  // clock and reset
  input  wire logic      clk,
  input  wire logic      sys_rst,
  // controller side
  input  wire logic      irq_req,
  input  wire clk_ctrl_t clk_ctrl,
  output logic           irq_ack,
  output logic           irq_return
);
  int   wait_cnt;   // cycles a request has waited
  logic in_handler; // a handler is running
  // take a request when running, return once it is gone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      in_handler <= 1'b0;
      wait_cnt   <= 0;
    end else begin
      irq_ack    <= 1'b0;
      irq_return <= 1'b0;
      if (in_handler && !irq_req) begin
        irq_return <= 1'b1;
        in_handler <= 1'b0;
      end else if (!in_handler && irq_req && clk_ctrl.cpu_run) begin
        wait_cnt <= wait_cnt + 1;
        // accept after the delay
        if (wait_cnt == ACK_DELAY) begin
          irq_ack    <= 1'b1;
          in_handler <= 1'b1;
          wait_cnt   <= 0;
        end
      end else begin
        wait_cnt <= 0;
      end
    end
  end
endmodule : core_model

// file: verif/testbench.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module testbench
  import irq_pkg::*;
;
  logic        clk;
  logic        sys_rst             = 1'b1;
  logic        power_up_clear      = 1'b0;
  axi_req_t    axi_req             = '0;
  axi_rsp_t    axi_rsp;
  logic        pin_reset_mode      = 1'b0;
  logic        pin_reset           = 1'b0;
  logic [2:0]  nmi_src             = 3'h0; // flash viol, pin nmi, osc fault
  logic        wdog_overflow       = 1'b0;
  logic        flash_key_violation = 1'b0;
  logic        true_nmi_req        = 1'b0;
  logic [3:0]  tmr                 = 4'h0; // overflow, channels 2..0
  logic [7:0]  port1_edge_flags    = 8'h00;
  logic [7:0]  port2_edge_flags    = 8'h00;
  logic        gie                 = 1'b0;
  logic        irq_ack;
  logic        irq_return;
  logic        irq_req;
  logic [15:0] irq_vector;
  logic        sys_reset_req;
  clk_ctrl_t   clk_ctrl;
  int          n_mismatch          = 0;
  int          total_checks        = 0;
  // clock pattern per mode, active then low-power 0..4
  localparam logic [5:0] CLK_EXP [6] = '{6'h3F, 6'h0F, 6'h0D, 6'h07, 6'h05, 6'h00};

  irq_vector_lowpower_ctrl irq_vector_lowpower_ctrl_i (
    .clk, .sys_rst, .power_up_clear, .axi_req, .axi_rsp, .pin_reset_mode, .pin_reset,
    .pin_nmi_req(nmi_src[1]), .wdog_overflow, .flash_key_violation,
    .osc_fault_det(nmi_src[0]), .flash_access_viol(nmi_src[2]), .true_nmi_req,
    .timer_channel0(tmr[0]), .timer_channel1(tmr[1]), .timer_channel2(tmr[2]),
    .timer_overflow_flag(tmr[3]), .port1_edge_flags, .port2_edge_flags, .gie, .irq_ack,
    .irq_return, .irq_req, .irq_vector, .sys_reset_req, .clk_ctrl);
  core_model #(.ACK_DELAY(8)) core_model_i (
    .clk, .sys_rst, .irq_req, .clk_ctrl, .irq_ack, .irq_return);

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // bus write: address and data together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr  <= a;
    axi_req.wvalid  <= 1'b1;
    axi_req.wdata   <= d;
    axi_req.wstrb   <= 4'hF;
    axi_req.bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
      if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
    end while (!axi_rsp.bvalid);
    axi_req.bready <= 1'b0;
    cmp(32'(axi_rsp.bresp), 32'(r));
  endtask : wr

  // bus read: hold rready until the answer is sampled
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr  <= a;
    axi_req.rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
    end while (!axi_rsp.rvalid);
    axi_req.rready <= 1'b0;
    cmp(axi_rsp.rdata, d);
    cmp(32'(axi_rsp.rresp), 32'(r));
  endtask : rd

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // watchdog: tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`ADDR_INT_EN_1, 32'h0, `RESP_OKAY);
    wr(`ADDR_INT_EN_1, 32'hFF, `RESP_OKAY);
    rd(`ADDR_INT_EN_1, 32'h33, `RESP_OKAY);
    rd(`ADDR_INT_EN_2, 32'h0, `RESP_OKAY);
    rd(8'h18, 32'h0, `RESP_SLVERR);
    power_up_clear <= 1'b1;
    tick(1);
    power_up_clear <= 1'b0;
    rd(`ADDR_INT_EN_1, 32'h0, `RESP_OKAY);
    // every mode and its clocks
    for (int m = 0; m < 6; m++) begin
      wr(`ADDR_MODE, 32'(m), `RESP_OKAY);
      tick(2);
      cmp(32'(clk_ctrl), 32'(CLK_EXP[m]));
    end
    wr(`ADDR_MODE, 32'h0A, `RESP_OKAY);
    tick(2);
    cmp(32'(clk_ctrl), 32'h0F);
    rd(`ADDR_MODE, 32'h0A, `RESP_OKAY);
    wr(`ADDR_MODE, 32'h07, `RESP_OKAY);
    rd(`ADDR_MODE, 32'h02, `RESP_OKAY);
    // wake from mode 3 and return to it
    wr(`ADDR_MODE, 32'h04, `RESP_OKAY);
    gie <= 1'b1;
    tmr <= 4'h1;
    tick(3);
    cmp(32'(clk_ctrl), 32'h3F);
    tick(12);
    tmr <= 4'h0;
    tick(6);
    cmp(32'(clk_ctrl), 32'h05);
    wr(`ADDR_MODE, 32'h0, `RESP_OKAY);
    // each maskable source alone
    for (int i = 0; i < 20; i++) begin
      {tmr, port2_edge_flags, port1_edge_flags} <= 20'h1 << i;
      tick(2);
      cmp(32'({irq_req, irq_vector}), i < 8 ? 32'h1FFE4 : i < 16 ? 32'h1FFE6 :
          i < 17 ? 32'h1FFF2 : 32'h1FFF0);
    end
    {tmr, port2_edge_flags, port1_edge_flags} <= 20'hFFFFF;
    tick(2);
    cmp(32'(irq_vector), 32'hFFF2);
    gie <= 1'b0;
    tick(2);
    cmp(32'(irq_req), 32'h0);
    {tmr, port2_edge_flags, port1_edge_flags} <= 20'h0;
    // slot 14 gated by own enables, not by gie
    nmi_src <= 3'h7;
    tick(1);
    nmi_src <= 3'h0;
    tick(2);
    cmp(32'(irq_req), 32'h0);
    rd(`ADDR_INT_FLAG_1, 32'h32, `RESP_OKAY);
    wr(`ADDR_INT_EN_1, 32'h10, `RESP_OKAY);
    tick(2);
    cmp(32'({irq_req, irq_vector}), 32'h1FFFC);
    wr(`ADDR_INT_EN_1, 32'h0, `RESP_OKAY);
    wr(`ADDR_INT_FLAG_1, 32'h0, `RESP_OKAY);
    true_nmi_req <= 1'b1;
    tick(2);
    cmp(32'({irq_req, irq_vector}), 32'h1FFFC);
    true_nmi_req <= 1'b0;
    // watchdog overflow, then interval mode request and ack
    wdog_overflow <= 1'b1;
    tick(1);
    wdog_overflow <= 1'b0;
    tick(1);
    cmp(32'(sys_reset_req), 32'h1);
    rd(`ADDR_INT_FLAG_1, 32'h01, `RESP_OKAY);
    wr(`ADDR_INT_EN_1, 32'h01, `RESP_OKAY);
    gie <= 1'b1;
    tick(2);
    cmp(32'(irq_req), 32'h0);
    wr(`ADDR_MODE, 32'h10, `RESP_OKAY);
    tick(2);
    cmp(32'(irq_vector), 32'hFFF4);
    tick(12);
    rd(`ADDR_INT_FLAG_1, 32'h0, `RESP_OKAY);
    // key violation sets, pin reset clears
    wr(`ADDR_INT_EN_1, 32'h0, `RESP_OKAY);
    flash_key_violation <= 1'b1;
    tick(1);
    flash_key_violation <= 1'b0;
    rd(`ADDR_INT_FLAG_1, 32'h01, `RESP_OKAY);
    pin_reset_mode <= 1'b1;
    pin_reset <= 1'b1;
    tick(2);
    pin_reset <= 1'b0;
    rd(`ADDR_INT_FLAG_1, 32'h0, `RESP_OKAY);
    end_of_test();
  end
endmodule : testbench

bind irq_vector_lowpower_ctrl irq_ctrl_monitor irq_ctrl_monitor_i (
  .clk, .sys_rst, .axi_req, .axi_rsp, .flash_key_violation, .true_nmi_req,
  .port1_edge_flags, .gie, .irq_req, .irq_vector, .sys_reset_req, .clk_ctrl);
